// ===== adc_sar_pkg.sv
package adc_sar_pkg;
  // Operating modes
  typedef enum logic [2:0] {
    MODE_FIX_SINGLE  = 3'h0,
    MODE_FIX_CONT    = 3'h1,
    MODE_SCAN_SINGLE = 3'h2,
    MODE_SCAN_CONT   = 3'h3,
    MODE_DUAL_CONT   = 3'h4
  } op_mode_t;
  // Conversion start modes
  typedef enum logic [1:0] {
    START_TIMER = 2'h0,
    START_NOW   = 2'h1,
    START_EDGE  = 2'h2
  } start_mode_t;
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_WAIT   = 2'h1,
    ST_SAMPLE = 2'h2,
    ST_CONV   = 2'h3
  } state_t;
endpackage : adc_sar_pkg

// ===== adc_sar_regs.svh
`ifndef ADC_SAR_REGS_SVH
`define ADC_SAR_REGS_SVH
// Register offsets
`define ADC_OFS_CTRL      4'h0
`define ADC_OFS_CHSEL     4'h1
`define ADC_OFS_IEN       4'h2
`define ADC_OFS_STATUS    4'h3
`define ADC_OFS_DIV       4'h4
`define ADC_OFS_BND_HI    4'h5
`define ADC_OFS_BND_LO    4'h6
`define ADC_OFS_RES0      4'h8
`define ADC_OFS_RES3      4'hB
// Control fields
`define ADC_CTRL_EN       0
`define ADC_CTRL_MODE_LSB 1
`define ADC_CTRL_MODE_MSB 3
`define ADC_CTRL_STRT_LSB 4
`define ADC_CTRL_STRT_MSB 5
`define ADC_CTRL_STEP     6
`define ADC_CTRL_RISE     7
// Channel select fields
`define ADC_CHS_MASK_MSB  3
`define ADC_CHS_A_LSB     4
`define ADC_CHS_B_LSB     6
// Enable fields
`define ADC_IEN_DONE      0
`define ADC_IEN_BND       1
`define ADC_IEN_DAC       2
// Status fields
`define ADC_ST_DONE       0
`define ADC_ST_BND        1
`define ADC_ST_BUSY       2
// Reset values
`define ADC_RST_CTRL      8'h00
`define ADC_RST_CHSEL     8'h01
`define ADC_RST_IEN       8'h00
`define ADC_RST_DIV       3'h0
`define ADC_RST_BND_HI    8'hFF
`define ADC_RST_BND_LO    8'h00
`define ADC_RST_RES       8'h00
// Approximation start value and last slot
`define ADC_SAR_INIT      8'h80
`define ADC_MSB_BIT       3'h7
`define ADC_EARLY_BIT     3'h4
`define ADC_LAST_SLOT     2'h3
`endif

// ===== adc_sar_sequencer_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_sar_regs.svh"
module adc_sar_sequencer_control #(
  parameter int NUM_CH = 4  // Channels and result registers
) (
  input  wire logic       core_clk_i,        // Peripheral clock
  input  wire logic       rst_i,             // Synchronous reset, active high
  input  wire logic [3:0] addr_i,            // Register address
  input  wire logic [7:0] wdata_i,           // Write data
  input  wire logic       we_i,              // Write strobe
  input  wire logic       re_i,              // Read strobe
  output logic      [7:0] rdata_o,           // Read data, cycle after strobe
  input  wire logic       timer0_ovf_i,      // Timer 0 overflow pulse
  input  wire logic       edge_start_pin_i,  // External start pin
  input  wire logic       comp_i,            // High: held input at or above DAC
  input  wire logic       idle_i,            // Device in idle mode
  input  wire logic       power_down_i,      // Power-down or total power-down
  output logic      [1:0] mux_sel_o,         // Analog multiplexer channel
  output logic            sample_o,          // Sample-and-hold tracking
  output logic      [7:0] dac_o,             // DAC code
  output logic            dac_out_en_o,      // DAC driven onto channel 3 pin
  output logic            busy_o,            // Conversion in progress
  output logic            irq_o,             // Interrupt request
  output logic            wake_o             // Idle wake-up request
);
  // Software registers
  logic [7:0] ctrl_q;                   // Enable, mode, start, step, polarity
  logic [7:0] chsel_q;                  // Scan mask, channel A, channel B
  logic [7:0] ien_q;                    // Interrupt enables, DAC mode
  logic [2:0] div_q;                    // Divisor minus one
  logic [7:0] bnd_hi_q;                 // High limit
  logic [7:0] bnd_lo_q;                 // Low limit
  logic [7:0] res_q [NUM_CH];           // Result registers
  logic       done_flag_q;              // Conversion complete flag
  logic       bnd_flag_q;               // Boundary flag
  // Converter state
  adc_sar_pkg::state_t state_q;         // Sequencer state
  logic [7:0] sar_q;                    // Approximation register
  logic [2:0] bit_q;                    // Bit under trial
  logic [1:0] ch_q;                     // Channel being converted
  logic [1:0] cnt_q;                    // Slot counter for rotating modes
  logic       early_hit_q;              // Early check already flagged
  logic [2:0] div_cnt_q;                // Clock divider count
  logic       pin_q;                    // Pin sample
  logic       pin_prev_q;               // Previous pin sample
  // Decoded fields
  logic                     enable;
  adc_sar_pkg::op_mode_t    mode;
  adc_sar_pkg::start_mode_t strt;
  logic       step_en;
  logic [3:0] ch_mask;
  logic [1:0] chan_a;
  logic [1:0] chan_b;
  logic       running;
  logic       tick;
  logic       edge_seen;
  logic       trig;
  logic       ctrl_wr;
  logic       scan_mode;
  logic [7:0] trial_mask;
  logic [7:0] res_bits;
  logic [7:0] sar_d;
  logic       last_bit;
  logic       conv_done;
  logic [1:0] slot;
  logic [2:0] next_ch;
  logic [2:0] first_ch;
  logic       done_set;
  logic       bnd_set;
  adc_sar_pkg::start_mode_t wr_strt;    // Start mode in the value being written
  logic       wr_scan;                  // Scan mode in the value being written

  assign enable  = ctrl_q[`ADC_CTRL_EN];
  assign mode    = adc_sar_pkg::op_mode_t'(ctrl_q[`ADC_CTRL_MODE_MSB:`ADC_CTRL_MODE_LSB]);
  assign strt    = adc_sar_pkg::start_mode_t'(ctrl_q[`ADC_CTRL_STRT_MSB:`ADC_CTRL_STRT_LSB]);
  assign step_en = ctrl_q[`ADC_CTRL_STEP];
  assign ch_mask = chsel_q[`ADC_CHS_MASK_MSB:0];
  assign chan_a  = chsel_q[`ADC_CHS_A_LSB +: 2];
  assign chan_b  = chsel_q[`ADC_CHS_B_LSB +: 2];
  assign ctrl_wr = we_i && (addr_i == `ADC_OFS_CTRL);
  assign scan_mode = (mode == adc_sar_pkg::MODE_SCAN_SINGLE) ||
                     (mode == adc_sar_pkg::MODE_SCAN_CONT);
  assign wr_strt = adc_sar_pkg::start_mode_t'(wdata_i[`ADC_CTRL_STRT_MSB:`ADC_CTRL_STRT_LSB]);
  assign wr_scan = (wdata_i[`ADC_CTRL_MODE_MSB -: 2] == 2'h1);  // Scan single or continuous

  // Converter logic only runs while enabled and not powered down
  assign running = enable && !power_down_i;

  // Next selected channel at or above a given index; bit 2 set means none
  function automatic logic [2:0] find_ch(input logic [3:0] mask, input logic [2:0] from);
    logic [2:0] r;
    r = 3'h4;
    for (int i = 3; i >= 0; i--) begin
      if (mask[i] && (3'(i) >= from)) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : find_ch

  assign first_ch = find_ch(ch_mask, 3'h0);
  assign next_ch  = find_ch(ch_mask, {1'b0, ch_q} + 3'h1);

  // Converter clock tick, one per div_q+1 peripheral clocks
  assign tick = running && (div_cnt_q == div_q);

  // Edge of the start pin of the chosen polarity
  assign edge_seen = ctrl_q[`ADC_CTRL_RISE] ? (pin_q && !pin_prev_q)
                                            : (!pin_q && pin_prev_q);

  // Triggers only count while armed, so busy-time triggers are dropped
  assign trig = (state_q == adc_sar_pkg::ST_WAIT) &&
                (((strt == adc_sar_pkg::START_TIMER) && timer0_ovf_i) ||
                 ((strt == adc_sar_pkg::START_EDGE) && edge_seen));

  // Successive approximation step: keep or drop trial bit
  assign trial_mask = 8'(8'h01 << bit_q);
  assign res_bits   = comp_i ? sar_q : (sar_q & ~trial_mask);
  assign last_bit   = (bit_q == 3'h0);
  assign sar_d      = last_bit ? res_bits : (res_bits | (trial_mask >> 1));
  assign conv_done  = tick && (state_q == adc_sar_pkg::ST_CONV) && last_bit;

  // Destination register of the finished conversion
  always_comb begin
    unique case (mode)
      adc_sar_pkg::MODE_FIX_CONT,
      adc_sar_pkg::MODE_DUAL_CONT: slot = cnt_q;
      adc_sar_pkg::MODE_FIX_SINGLE: slot = chan_a;
      default:                      slot = ch_q;
    endcase
  end

  // Completion flag events per mode
  always_comb begin
    done_set = 1'b0;
    if (conv_done) begin
      unique case (mode)
        adc_sar_pkg::MODE_FIX_CONT,
        adc_sar_pkg::MODE_DUAL_CONT: done_set = (cnt_q == `ADC_LAST_SLOT);
        adc_sar_pkg::MODE_SCAN_SINGLE,
        adc_sar_pkg::MODE_SCAN_CONT: done_set = next_ch[2] || step_en;
        default:                     done_set = 1'b1;
      endcase
    end
  end

  // Boundary events: early nibble, else full result
  always_comb begin
    bnd_set = 1'b0;
    if (ien_q[`ADC_IEN_BND] && tick && (state_q == adc_sar_pkg::ST_CONV)) begin
      if (bit_q == `ADC_EARLY_BIT) begin
        bnd_set = (res_bits[7:4] > bnd_hi_q[7:4]) || (res_bits[7:4] < bnd_lo_q[7:4]);
      end else if (last_bit && !early_hit_q) begin
        bnd_set = (res_bits > bnd_hi_q) || (res_bits < bnd_lo_q);
      end
    end
  end

  // Software register writes
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl_q   <= `ADC_RST_CTRL;
      chsel_q  <= `ADC_RST_CHSEL;
      ien_q    <= `ADC_RST_IEN;
      div_q    <= `ADC_RST_DIV;
      bnd_hi_q <= `ADC_RST_BND_HI;
      bnd_lo_q <= `ADC_RST_BND_LO;
    end else if (we_i) begin
      unique case (addr_i)
        `ADC_OFS_CTRL:   ctrl_q   <= wdata_i;
        `ADC_OFS_CHSEL:  chsel_q  <= wdata_i;
        `ADC_OFS_IEN:    ien_q    <= wdata_i;
        `ADC_OFS_DIV:    div_q    <= wdata_i[2:0];
        `ADC_OFS_BND_HI: bnd_hi_q <= wdata_i;
        `ADC_OFS_BND_LO: bnd_lo_q <= wdata_i;
        default: ;  // Other offsets hold no writable control
      endcase
    end
  end

  // Sticky flags; a hardware set beats a write-one clear
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      done_flag_q <= 1'b0;
      bnd_flag_q  <= 1'b0;
    end else begin
      if (done_set) begin
        done_flag_q <= 1'b1;
      end else if (we_i && (addr_i == `ADC_OFS_STATUS) && wdata_i[`ADC_ST_DONE]) begin
        done_flag_q <= 1'b0;
      end
      if (bnd_set) begin
        bnd_flag_q <= 1'b1;
      end else if (we_i && (addr_i == `ADC_OFS_STATUS) && wdata_i[`ADC_ST_BND]) begin
        bnd_flag_q <= 1'b0;
      end
    end
  end

  // Result registers; slot 3 also takes the DAC value from software
  for (genvar g = 0; g < NUM_CH; g++) begin : g_res
    always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
        res_q[g] <= `ADC_RST_RES;
      end else if (conv_done && (slot == 2'(g))) begin
        res_q[g] <= res_bits;
      end else if (we_i && (addr_i == `ADC_OFS_RES0 + 4'(g)) && (g == NUM_CH - 1)) begin
        res_q[g] <= wdata_i;
      end
    end
  end

  // Converter clock divider, held at zero while stopped to save power
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !running || tick) begin
      div_cnt_q <= 3'h0;
    end else begin
      div_cnt_q <= div_cnt_q + 3'h1;
    end
  end

  // Start pin samples for edge detection
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pin_q      <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      pin_q      <= edge_start_pin_i;
      pin_prev_q <= pin_q;
    end
  end

  // Sequencer: arming, sampling, bit trials and channel stepping
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q     <= adc_sar_pkg::ST_IDLE;
      sar_q       <= 8'h00;
      bit_q       <= `ADC_MSB_BIT;
      ch_q        <= 2'h0;
      cnt_q       <= 2'h0;
      early_hit_q <= 1'b0;
    end else if (ctrl_wr) begin
      // Decode the value being written, since the stored one is still stale here
      if (!wdata_i[`ADC_CTRL_EN] || power_down_i || ien_q[`ADC_IEN_DAC]) begin
        state_q <= adc_sar_pkg::ST_IDLE;
      end else if (state_q == adc_sar_pkg::ST_WAIT && wr_strt == adc_sar_pkg::START_NOW) begin
        state_q <= adc_sar_pkg::ST_SAMPLE;
      end else if (wr_scan && first_ch[2]) begin
        state_q <= adc_sar_pkg::ST_IDLE;   // Empty scan set: nothing to do
      end else begin
        cnt_q   <= 2'h0;
        ch_q    <= wr_scan ? first_ch[1:0] : chan_a;
        state_q <= (wr_strt == adc_sar_pkg::START_NOW) ? adc_sar_pkg::ST_SAMPLE
                                                        : adc_sar_pkg::ST_WAIT;
      end
    end else if (!running || ien_q[`ADC_IEN_DAC]) begin
      state_q <= adc_sar_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        adc_sar_pkg::ST_IDLE: ;
        adc_sar_pkg::ST_WAIT: begin
          if (trig) begin
            state_q <= adc_sar_pkg::ST_SAMPLE;
          end
        end
        adc_sar_pkg::ST_SAMPLE: begin
          if (tick) begin
            state_q     <= adc_sar_pkg::ST_CONV;
            sar_q       <= `ADC_SAR_INIT;
            bit_q       <= `ADC_MSB_BIT;
            early_hit_q <= 1'b0;
          end
        end
        adc_sar_pkg::ST_CONV: begin
          if (tick) begin
            sar_q <= sar_d;
            bit_q <= bit_q - 3'h1;
            if (bnd_set) begin
              early_hit_q <= 1'b1;
            end
            if (last_bit) begin
              unique case (mode)
                adc_sar_pkg::MODE_FIX_SINGLE: state_q <= adc_sar_pkg::ST_IDLE;
                adc_sar_pkg::MODE_FIX_CONT: begin
                  cnt_q   <= cnt_q + 2'h1;
                  state_q <= adc_sar_pkg::ST_SAMPLE;
                end
                adc_sar_pkg::MODE_DUAL_CONT: begin
                  cnt_q   <= cnt_q + 2'h1;
                  ch_q    <= cnt_q[0] ? chan_a : chan_b;
                  state_q <= adc_sar_pkg::ST_SAMPLE;
                end
                default: begin
                  if (!next_ch[2]) begin
                    ch_q    <= next_ch[1:0];
                    state_q <= step_en ? adc_sar_pkg::ST_WAIT
                                       : adc_sar_pkg::ST_SAMPLE;
                  end else if (mode == adc_sar_pkg::MODE_SCAN_CONT) begin
                    ch_q    <= first_ch[1:0];
                    state_q <= step_en ? adc_sar_pkg::ST_WAIT
                                       : adc_sar_pkg::ST_SAMPLE;
                  end else begin
                    state_q <= adc_sar_pkg::ST_IDLE;
                  end
                end
              endcase
            end
          end
        end
      endcase
    end
  end

  // Analog-side outputs, all registered
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mux_sel_o    <= 2'h0;
      sample_o     <= 1'b0;
      dac_o        <= 8'h00;
      dac_out_en_o <= 1'b0;
      busy_o       <= 1'b0;
    end else begin
      mux_sel_o    <= ch_q;
      sample_o     <= (state_q == adc_sar_pkg::ST_SAMPLE);
      // DAC mode shows the stored value; otherwise the trial code
      dac_o        <= ien_q[`ADC_IEN_DAC] ? res_q[NUM_CH-1] : sar_q;
      dac_out_en_o <= ien_q[`ADC_IEN_DAC] && running;
      busy_o       <= (state_q == adc_sar_pkg::ST_SAMPLE) ||
                      (state_q == adc_sar_pkg::ST_CONV);
    end
  end

  // Interrupt request and idle wake-up
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_o  <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      irq_o  <= (done_flag_q && ien_q[`ADC_IEN_DONE]) ||
                (bnd_flag_q && ien_q[`ADC_IEN_BND]);
      wake_o <= idle_i && done_flag_q && ien_q[`ADC_IEN_DONE];
    end
  end

  // Read data for exactly one cycle after the strobe
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !re_i) begin
      rdata_o <= 8'h00;
    end else begin
      unique case (addr_i)
        `ADC_OFS_CTRL:   rdata_o <= ctrl_q;
        `ADC_OFS_CHSEL:  rdata_o <= chsel_q;
        `ADC_OFS_IEN:    rdata_o <= {5'h00, ien_q[2:0]};
        `ADC_OFS_STATUS: rdata_o <= {5'h00, busy_o, bnd_flag_q, done_flag_q};
        `ADC_OFS_DIV:    rdata_o <= {5'h00, div_q};
        `ADC_OFS_BND_HI: rdata_o <= bnd_hi_q;
        `ADC_OFS_BND_LO: rdata_o <= bnd_lo_q;
        4'h8:            rdata_o <= res_q[0];
        4'h9:            rdata_o <= res_q[1];
        4'hA:            rdata_o <= res_q[2];
        `ADC_OFS_RES3:   rdata_o <= res_q[3];
        default:         rdata_o <= 8'h00;  // Unmapped reads as zero
      endcase
    end
  end
endmodule : adc_sar_sequencer_control
`default_nettype wire

// ===== adc_sar_sequencer_control_checker.sv
`timescale 1ns/1ps
`default_nettype none
module adc_sar_sequencer_control_checker #(
  parameter int NUM_CH = 4  // Mirrors the design
) (
  input wire logic       core_clk_i,    // Peripheral clock
  input wire logic       rst_i,         // Synchronous reset
  input wire logic [3:0] addr_i,        // Register address
  input wire logic [7:0] wdata_i,       // Write data
  input wire logic       we_i,          // Write strobe
  input wire logic       idle_i,        // Idle mode
  input wire logic       power_down_i,  // Power-down
  input wire logic       sample_o,      // Sampling
  input wire logic [7:0] dac_o,         // DAC code
  input wire logic       dac_out_en_o,  // DAC onto pin
  input wire logic       busy_o,        // Converting
  input wire logic       irq_o,         // Interrupt request
  input wire logic       wake_o         // Idle wake-up
);
  logic [1:0] ien_q;  // Shadow of both interrupt enables
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Shadow follows enable writes, so irq can be tied to its cause
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ien_q <= 2'h0;
    end else if (we_i && addr_i == 4'h2) begin
      ien_q <= wdata_i[1:0];
    end
  end
  sequence s_ctrl_off;
    we_i && addr_i == 4'h0 && !wdata_i[0];
  endsequence
  sequence s_pd_held;
    power_down_i ##1 power_down_i;
  endsequence
  sequence s_dac_load;
    dac_out_en_o && we_i && addr_i == 4'hB;
  endsequence
  a_off_stops_conv: assert property (s_ctrl_off |-> ##2 !busy_o && !sample_o)
    else $error("converter active after disable");
  a_pd_stops_conv: assert property (s_pd_held |=> !busy_o && !sample_o)
    else $error("converter active in power-down");
  a_wake_needs_idle: assert property (wake_o |-> $past(idle_i))
    else $error("wake without idle");
  a_wake_with_irq: assert property (wake_o |-> irq_o)
    else $error("wake without interrupt request");
  a_irq_needs_enable: assert property (irq_o |-> $past(ien_q) != 2'h0)
    else $error("interrupt with both enables clear");
  a_sample_while_busy: assert property (sample_o |-> busy_o)
    else $error("sampling while not busy");
  a_dac_mode_halts: assert property (dac_out_en_o [*3] |-> !busy_o && !sample_o)
    else $error("conversion running in DAC mode");
  a_dac_follows_write: assert property (s_dac_load ##1 dac_out_en_o |=> dac_o == $past(wdata_i, 2))
    else $error("DAC code differs from written value");
endmodule : adc_sar_sequencer_control_checker
bind adc_sar_sequencer_control adc_sar_sequencer_control_checker #(.NUM_CH(NUM_CH))
  u_adc_sar_sequencer_control_checker (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
  .idle_i(idle_i), .power_down_i(power_down_i), .sample_o(sample_o), .dac_o(dac_o),
  .dac_out_en_o(dac_out_en_o), .busy_o(busy_o), .irq_o(irq_o), .wake_o(wake_o));
`default_nettype wire

// ===== analog_front_model.sv
`timescale 1ns/1ps
`default_nettype none
module analog_front_model (
  input  wire logic        core_clk_i,  // Peripheral clock
  input  wire logic [1:0]  mux_sel_i,   // Selected channel
  input  wire logic        sample_i,    // Track while high
  input  wire logic [7:0]  dac_i,       // DAC trial code
  input  wire logic [31:0] ain_i,       // Four levels, channel 0 lowest
  output logic             comp_o       // Held level at or above DAC
);
  logic [7:0] held_q = 8'h00;  // Level frozen when sampling ends
  // Hold node tracks the chosen input only while sampling
  always_ff @(posedge core_clk_i) begin
    if (sample_i) begin
      held_q <= ain_i[8 * mux_sel_i +: 8];
    end
  end
  // Ideal comparator: no offset, so a correct search lands on the level
  assign comp_o = (held_q >= dac_i);
endmodule : analog_front_model
`default_nettype wire

// ===== test_adc_sar_sequencer_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_adc_sar_sequencer_control;
  logic        core_clk_i       = 1'b0;          // Peripheral clock
  logic        rst_i            = 1'b1;          // Reset
  logic [3:0]  addr_i           = 4'h0;          // Register bus
  logic [7:0]  wdata_i          = 8'h00;
  logic        we_i             = 1'b0;
  logic        re_i             = 1'b0;
  logic        timer0_ovf_i     = 1'b0;          // Start sources
  logic        edge_start_pin_i = 1'b0;
  logic        idle_i           = 1'b0;          // Power states
  logic        power_down_i     = 1'b0;
  logic [31:0] ain              = 32'h0;         // Levels at the model
  logic [31:0] ain_exp;                          // Same, for expectations
  logic [31:0] seed             = 32'h921A2DC0;  // Xorshift state
  logic [7:0]  rdata_o, dac_o, st, d, v, hi, lo;
  logic [1:0]  mux_sel_o;
  logic        sample_o, dac_out_en_o, busy_o, irq_o, wake_o, comp_i, e;
  int          failures = 0;
  int          total_checks = 0;
  int          cycles = 0;
  always #2.5 core_clk_i = ~core_clk_i;
  adc_sar_sequencer_control #(.NUM_CH(4)) u_adc_sar_sequencer_control (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .timer0_ovf_i(timer0_ovf_i),
    .edge_start_pin_i(edge_start_pin_i), .comp_i(comp_i), .idle_i(idle_i),
    .power_down_i(power_down_i), .mux_sel_o(mux_sel_o), .sample_o(sample_o),
    .dac_o(dac_o), .dac_out_en_o(dac_out_en_o), .busy_o(busy_o), .irq_o(irq_o),
    .wake_o(wake_o));
  analog_front_model u_analog_front_model (
    .core_clk_i(core_clk_i), .mux_sel_i(mux_sel_o), .sample_i(sample_o),
    .dac_i(dac_o), .ain_i(ain), .comp_o(comp_i));
  // Hang guard, far above the planned run length
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (failures == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  function automatic logic [7:0] r8();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : r8
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] dt);
    @(posedge core_clk_i);
    we_i <= 1'b1;
    addr_i <= a;
    wdata_i <= dt;
    @(posedge core_clk_i);
    we_i <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] dt);
    @(posedge core_clk_i);
    re_i <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    re_i <= 1'b0;
    #1;
    dt = rdata_o;
  endtask : rd
  task automatic go(input logic [2:0] md, input logic [1:0] sm, input logic [1:0] fl);
    wr(4'h0, {fl, sm, md, 1'b1});
  endtask : go
  // Poll the done flag; bounded so a dead sequencer cannot hang us
  task automatic wait_done();
    st = 8'h00;
    for (int i = 0; i < 400 && st[0] !== 1'b1; i++) begin
      rd(4'h3, st);
    end
  endtask : wait_done
  task automatic new_ain();
    ain_exp = {r8(), r8(), r8(), r8()};
    ain <= ain_exp;
  endtask : new_ain
  // Channel whose level belongs in result register i, 4 for none
  function automatic int pick(input logic [2:0] md, input logic [7:0] cs, input int i);
    case (md)
      adc_sar_pkg::MODE_FIX_SINGLE: return (i == cs[5:4]) ? int'(cs[5:4]) : 4;
      adc_sar_pkg::MODE_FIX_CONT:   return int'(cs[5:4]);
      adc_sar_pkg::MODE_DUAL_CONT:  return i[0] ? int'(cs[7:6]) : int'(cs[5:4]);
      default:                      return cs[i] ? i : 4;
    endcase
  endfunction : pick
  task automatic run_mode(input logic [2:0] md);
    logic [7:0] cs;
    int p;
    cs = r8();
    cs[0] = cs[0] | (cs[3:0] == 4'h0);     // Mask never empty
    cs[6] = cs[6] ^ (cs[7:6] == cs[5:4]);  // Dual inputs differ
    new_ain();
    wr(4'h1, cs);
    go(md, adc_sar_pkg::START_NOW, 2'b00);
    wait_done();
    chk({7'h00, irq_o}, 8'h01);
    wr(4'h0, 8'h00);
    wr(4'h3, 8'h03);
    for (int i = 0; i < 4; i++) begin
      rd(4'h8 + i[3:0], d);
      p = pick(md, cs, i);
      if (p < 4) chk(d, ain_exp[8 * p +: 8]);
    end
  endtask : run_mode
  task automatic trig(input int k);
    if (k == 0) timer0_ovf_i <= 1'b1;
    else edge_start_pin_i <= ~edge_start_pin_i;
    @(posedge core_clk_i);
    timer0_ovf_i <= 1'b0;
  endtask : trig
  initial begin
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    // Reset values; unmapped places read zero
    for (int i = 0; i < 16; i++) begin
      rd(i[3:0], d);
      chk(d, (i == 1) ? 8'h01 : (i == 5) ? 8'hFF : 8'h00);
    end
    v = (r8() & 8'h07) | 8'h01;
    wr(4'h4, v);
    rd(4'h4, d);
    chk(d, v);
    wr(4'h2, 8'h01);
    for (int m = 0; m < 10; m++) run_mode(3'(m % 5));
    // Single step waits for a fresh start after each channel
    wr(4'h1, 8'h0F);
    go(adc_sar_pkg::MODE_SCAN_SINGLE, adc_sar_pkg::START_NOW, 2'b01);
    wait_done();
    wr(4'h3, 8'h03);
    repeat (60) @(posedge core_clk_i);
    chk({7'h00, busy_o}, 8'h00);
    go(adc_sar_pkg::MODE_SCAN_SINGLE, adc_sar_pkg::START_NOW, 2'b01);
    wait_done();
    chk(st & 8'h01, 8'h01);
    wr(4'h0, 8'h00);
    wr(4'h3, 8'h03);
    // Boundary limits, enable drawn at random, some at the exact limit
    wr(4'h1, 8'h01);
    repeat (10) begin
      v = r8();
      hi = r8();
      lo = r8();
      new_ain();
      if (v[1]) hi = ain_exp[7:0];
      if (v[2]) lo = 8'h00;
      e = v[0] && (ain_exp[7:0] > hi || ain_exp[7:0] < lo);
      wr(4'h5, hi);
      wr(4'h6, lo);
      wr(4'h2, {6'h00, v[0], 1'b0});
      go(adc_sar_pkg::MODE_FIX_SINGLE, adc_sar_pkg::START_NOW, 2'b00);
      wait_done();
      chk(st & 8'h02, {6'h00, e, 1'b0});
      chk({7'h00, irq_o}, {7'h00, e});
      wr(4'h3, 8'h03);
    end
    // Timer start, then rising and falling pin edges
    for (int k = 0; k < 3; k++) begin
      edge_start_pin_i <= (k == 1);
      new_ain();
      repeat (4) @(posedge core_clk_i);
      go(adc_sar_pkg::MODE_FIX_SINGLE, (k == 0) ? adc_sar_pkg::START_TIMER
         : adc_sar_pkg::START_EDGE, {k == 1, 1'b0});
      repeat (4) @(posedge core_clk_i);
      edge_start_pin_i <= ~edge_start_pin_i;
      repeat (8) @(posedge core_clk_i);
      chk({7'h00, busy_o}, 8'h00);
      trig(k);
      repeat (6) @(posedge core_clk_i);
      chk({7'h00, busy_o}, 8'h01);
      trig(k);
      repeat (2) @(posedge core_clk_i);
      trig(k);
      wait_done();
      wr(4'h3, 8'h03);
      repeat (20) @(posedge core_clk_i);
      chk({7'h00, busy_o}, 8'h00);
      rd(4'h8, d);
      chk(d, ain_exp[7:0]);
    end
    // DAC mode shows the written code on the pin
    wr(4'h2, 8'h04);
    v = r8();
    wr(4'hB, v);
    repeat (3) @(posedge core_clk_i);
    chk(dac_o, v);
    chk({7'h00, dac_out_en_o}, 8'h01);
    wr(4'h2, 8'h01);
    // Power-down refuses, disable aborts
    power_down_i <= 1'b1;
    go(adc_sar_pkg::MODE_FIX_CONT, adc_sar_pkg::START_NOW, 2'b00);
    repeat (30) @(posedge core_clk_i);
    chk({7'h00, busy_o}, 8'h00);
    power_down_i <= 1'b0;
    go(adc_sar_pkg::MODE_FIX_SINGLE, adc_sar_pkg::START_NOW, 2'b00);
    repeat (6) @(posedge core_clk_i);
    wr(4'h0, 8'h00);
    repeat (60) @(posedge core_clk_i);
    rd(4'h3, d);
    chk(d & 8'h05, 8'h00);
    // Completion in idle raises wake-up
    idle_i <= 1'b1;
    go(adc_sar_pkg::MODE_FIX_SINGLE, adc_sar_pkg::START_NOW, 2'b00);
    wait_done();
    @(posedge core_clk_i);
    chk({7'h00, wake_o}, 8'h01);
    idle_i <= 1'b0;
    wr(4'h3, 8'h03);
    complete_run();
  end
endmodule : test_adc_sar_sequencer_control
`default_nettype wire
